// File: hims_defs.svh
// Purpose: Constants for the host interface mode select block
// Assumes: 200 MHz core clock
// Notes:   Timing counts derive from the time constants
`ifndef HIMS_DEFS_SVH
`define HIMS_DEFS_SVH
`define HIMS_CLK_PERIOD_PS    5000
`define HIMS_INIT_TIME_NS     100
`define HIMS_INIT_CYCLES      ((`HIMS_INIT_TIME_NS * 1000 + `HIMS_CLK_PERIOD_PS - 1) / `HIMS_CLK_PERIOD_PS)
`define HIMS_SENSE_CH         16
`define HIMS_REF_CH           2
`define HIMS_CNT_W            8
`endif

// File: hims_pkg.sv
// Purpose: Types for the host interface mode select block
// Assumes: Nothing
// Notes:   Mode and init state types
package hims_pkg;
   typedef enum logic {HIMS_MODE_I2C, HIMS_MODE_SPI} hims_mode_e;
   typedef enum logic [1:0] {HIMS_ST_RESET, HIMS_ST_INIT, HIMS_ST_RUN} hims_state_e;
endpackage : hims_pkg

// File: hims_sync_if.sv
// Purpose: Carrier for synchronised pin levels
// Assumes: Single clock domain
// Notes:   Producer is the synchroniser bank
`timescale 1ns/1ps
interface hims_sync_if;
   logic cs_n;
   logic scl;
   logic sda;
   logic addr0;
   logic addr1;
   modport prod (output cs_n, output scl, output sda, output addr0, output addr1);
   modport cons (input cs_n, input scl, input sda, input addr0, input addr1);
endinterface : hims_sync_if

// File: hims_sync.sv
// Purpose: Two-flop synchronisers for the serial pins
// Assumes: Pins are asynchronous to CLK
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module hims_sync #(
   parameter int W = 5
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Raw pins
   input  wire logic [W-1:0] pins,
   // Synchronised levels
   hims_sync_if.prod         so
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   // Idle high so a held-high select never looks like a fall
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= {W{1'b1}};
         sync_reg <= {W{1'b1}};
      end else begin
         meta_reg <= pins;
         sync_reg <= meta_reg;
      end
   end

   assign so.cs_n  = sync_reg[0];
   assign so.scl   = sync_reg[1];
   assign so.sda   = sync_reg[2];
   assign so.addr0 = sync_reg[3];
   assign so.addr1 = sync_reg[4];
endmodule : hims_sync

// File: hims_top.sv
// Purpose: Host serial interface mode select and pin role assignment
// Assumes: Protocol engines sit outside and use the routed signals
// Notes:   SPI mode, once entered on a select fall, is latched until the next initialization
`timescale 1ns/1ps
`include "hims_defs.svh"
module hims_top
   import hims_pkg::*;
#(
   parameter int NSENSE = `HIMS_SENSE_CH,
   parameter int NREF   = `HIMS_REF_CH
) (
   // Clock and reset
   input  wire logic            CLK,
   input  wire logic            RESETN,
   input  wire logic            EXTERNAL_RESET_N,
   // Serial pins
   input  wire logic            MODE_SELECT_CHIP_SELECT_N,
   input  wire logic            SERIAL_CLOCK_PIN,
   input  wire logic            SERIAL_DATA_PIN_I,
   output logic                 SERIAL_DATA_PIN_O,
   output logic                 SERIAL_DATA_PIN_OE,
   input  wire logic            ADDR0_OR_SERIAL_OUT_PIN_I,
   output logic                 ADDR0_OR_SERIAL_OUT_PIN_O,
   output logic                 ADDR0_OR_SERIAL_OUT_PIN_OE,
   input  wire logic            ADDR1_SELECT_PIN,
   // Sense pin enables
   output logic [NSENSE-1:0]    SENSE_INPUTS_OE,
   output logic [NREF-1:0]      REFERENCE_CAP_OE,
   // Core side
   input  wire logic [NSENSE-1:0] CORE_SENSE_OE,
   input  wire logic [NREF-1:0]   CORE_REF_OE,
   input  wire logic            CORE_IRQ,
   input  wire logic            CORE_I2C_SDA_OE,
   input  wire logic            CORE_SPI_SO,
   output logic                 INTERRUPT_OUTPUT,
   output logic                 SPI_MODE,
   output logic                 DEVICE_READY,
   output logic                 I2C_SCL,
   output logic                 I2C_SDA,
   output logic                 I2C_ADDR0,
   output logic                 I2C_ADDR1,
   output logic                 SPI_SCK,
   output logic                 SPI_SI,
   output logic                 SPI_CS_N
);
   hims_sync_if sif ();
   hims_state_e state_reg, state_next;
   hims_mode_e  mode_reg, mode_next;
   logic [`HIMS_CNT_W-1:0] cnt_reg, cnt_next;
   logic        rst_meta_reg, rst_sync_reg;
   logic        cs_prev_reg;
   wire logic   run      = (state_reg == HIMS_ST_RUN);
   wire logic   cs_fall  = cs_prev_reg & ~sif.cs_n;
   wire logic   spi      = (mode_reg == HIMS_MODE_SPI);
   wire logic   in_reset = ~rst_sync_reg;

   hims_sync #(.W(5)) u_sync (
      .clk  (CLK),
      .rst_n(RESETN),
      .pins ({ADDR1_SELECT_PIN, ADDR0_OR_SERIAL_OUT_PIN_I, SERIAL_DATA_PIN_I,
              SERIAL_CLOCK_PIN, MODE_SELECT_CHIP_SELECT_N}),
      .so   (sif)
   );

   // External reset pin is asynchronous, so it gets its own two flops
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= EXTERNAL_RESET_N;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   always_comb begin
      state_next = state_reg;
      mode_next  = mode_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         HIMS_ST_RESET: begin
            mode_next = HIMS_MODE_I2C;
            cnt_next  = '0;
            if (!in_reset) state_next = HIMS_ST_INIT;
         end
         HIMS_ST_INIT: begin
            mode_next = HIMS_MODE_I2C;
            cnt_next  = cnt_reg + `HIMS_CNT_W'(1);
            if (cnt_reg == `HIMS_CNT_W'(`HIMS_INIT_CYCLES - 1)) state_next = HIMS_ST_RUN;
         end
         HIMS_ST_RUN: begin
            // Sticky: later select levels never return to I2C
            if (cs_fall) mode_next = HIMS_MODE_SPI;
         end
         default: state_next = HIMS_ST_RESET;
      endcase
      if (in_reset) begin
         state_next = HIMS_ST_RESET;
         mode_next  = HIMS_MODE_I2C;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg   <= HIMS_ST_RESET;
         mode_reg    <= HIMS_MODE_I2C;
         cnt_reg     <= '0;
         cs_prev_reg <= 1'b1;
      end else begin
         state_reg   <= state_next;
         mode_reg    <= mode_next;
         cnt_reg     <= cnt_next;
         // Edge history held high until running, so a pin held low through init reads as a fall on the first run cycle
         cs_prev_reg <= run ? sif.cs_n : 1'b1;
      end
   end

   // Registered pin routing; one cycle after mode change
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         SERIAL_DATA_PIN_O          <= 1'b0;
         SERIAL_DATA_PIN_OE         <= 1'b0;
         ADDR0_OR_SERIAL_OUT_PIN_O  <= 1'b0;
         ADDR0_OR_SERIAL_OUT_PIN_OE <= 1'b0;
         SENSE_INPUTS_OE            <= '0;
         REFERENCE_CAP_OE           <= '0;
         INTERRUPT_OUTPUT           <= 1'b0;
         SPI_MODE                   <= 1'b0;
         DEVICE_READY               <= 1'b0;
         I2C_SCL                    <= 1'b1;
         I2C_SDA                    <= 1'b1;
         I2C_ADDR0                  <= 1'b0;
         I2C_ADDR1                  <= 1'b0;
         SPI_SCK                    <= 1'b0;
         SPI_SI                     <= 1'b0;
         SPI_CS_N                   <= 1'b1;
      end else begin
         SERIAL_DATA_PIN_O          <= 1'b0;
         SERIAL_DATA_PIN_OE         <= run & ~spi & CORE_I2C_SDA_OE;
         ADDR0_OR_SERIAL_OUT_PIN_O  <= CORE_SPI_SO;
         ADDR0_OR_SERIAL_OUT_PIN_OE <= run & spi & ~sif.cs_n;
         SENSE_INPUTS_OE            <= in_reset ? '0 : CORE_SENSE_OE;
         REFERENCE_CAP_OE           <= in_reset ? '0 : CORE_REF_OE;
         INTERRUPT_OUTPUT           <= run & CORE_IRQ;
         SPI_MODE                   <= spi;
         DEVICE_READY               <= run;
         I2C_SCL                    <= spi ? 1'b1 : sif.scl;
         I2C_SDA                    <= spi ? 1'b1 : sif.sda;
         I2C_ADDR0                  <= spi ? 1'b0 : sif.addr0;
         I2C_ADDR1                  <= spi ? 1'b0 : sif.addr1;
         SPI_SCK                    <= spi ? sif.scl : 1'b0;
         SPI_SI                     <= spi ? sif.sda : 1'b0;
         SPI_CS_N                   <= spi ? sif.cs_n : 1'b1;
      end
   end
endmodule : hims_top

// File: hims_chk.sv
// Purpose: Port checker for the mode select block
// Assumes: One core clock domain
// Notes:   Pins reach the routed outputs 3 cycles after they are sampled
`timescale 1ns/1ps
module hims_chk #(
   parameter int NSENSE = 16,
   parameter int NREF   = 2
) (
   // Clock and reset
   input wire logic              CLK,
   input wire logic              RESETN,
   input wire logic              EXTERNAL_RESET_N,
   // Pins
   input wire logic              MODE_SELECT_CHIP_SELECT_N,
   input wire logic              SERIAL_CLOCK_PIN,
   input wire logic              SERIAL_DATA_PIN_I,
   input wire logic              SERIAL_DATA_PIN_OE,
   input wire logic              ADDR0_OR_SERIAL_OUT_PIN_OE,
   input wire logic [NSENSE-1:0] SENSE_INPUTS_OE,
   input wire logic [NREF-1:0]   REFERENCE_CAP_OE,
   // Core side
   input wire logic              INTERRUPT_OUTPUT,
   input wire logic              SPI_MODE,
   input wire logic              DEVICE_READY,
   input wire logic              I2C_SCL,
   input wire logic              I2C_SDA,
   input wire logic              SPI_SCK,
   input wire logic              SPI_SI,
   input wire logic              SPI_CS_N
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   // Two sync stages plus the output flop, so enables clear by the fourth low sample
   sequence ext_low4;
      !EXTERNAL_RESET_N [*4];
   endsequence
   // Ready, mode and interrupt pass the state register too, one stage later
   sequence ext_low5;
      !EXTERNAL_RESET_N [*5];
   endsequence
   chk_i2c_default: assert property ($rose(DEVICE_READY) |-> !SPI_MODE)
      else $error("mode not I2C at ready");
   chk_spi_entry: assert property ($rose(SPI_MODE) |-> DEVICE_READY &&
      !$past(MODE_SELECT_CHIP_SELECT_N, 3)) else $error("SPI entered without fall");
   chk_spi_sticky: assert property (SPI_MODE && EXTERNAL_RESET_N |=> SPI_MODE)
      else $error("SPI mode lost");
   chk_cs_route: assert property (SPI_MODE && $past(SPI_MODE, 3) |->
      SPI_CS_N == $past(MODE_SELECT_CHIP_SELECT_N, 3)) else $error("chip select wrong");
   chk_hiz_reset: assert property (ext_low4 |-> SENSE_INPUTS_OE == '0 &&
      REFERENCE_CAP_OE == '0) else $error("sense pins driven in reset");
   chk_hold_reset: assert property (ext_low5 |-> !DEVICE_READY && !SPI_MODE &&
      !INTERRUPT_OUTPUT) else $error("not held in reset");
   chk_sda_input: assert property (SPI_MODE |-> !SERIAL_DATA_PIN_OE)
      else $error("data pin driven in SPI");
   chk_so_drive: assert property (!SPI_MODE |-> !ADDR0_OR_SERIAL_OUT_PIN_OE)
      else $error("address pin driven in I2C");
   chk_clk_route: assert property (DEVICE_READY && $past(DEVICE_READY, 3) &&
      SPI_MODE == $past(SPI_MODE, 3) |-> (SPI_MODE ? SPI_SCK : I2C_SCL) ==
      $past(SERIAL_CLOCK_PIN, 3)) else $error("serial clock misrouted");
   chk_data_route: assert property (DEVICE_READY && $past(DEVICE_READY, 3) &&
      SPI_MODE == $past(SPI_MODE, 3) |-> (SPI_MODE ? SPI_SI : I2C_SDA) ==
      $past(SERIAL_DATA_PIN_I, 3)) else $error("serial data misrouted");
endmodule : hims_chk
bind hims_top hims_chk #(.NSENSE(NSENSE), .NREF(NREF)) hims_chk_i (.*);

// File: hims_host.sv
// Purpose: Host model on the shared serial pins
// Assumes: Link clock of 125 ns, still outside frames
// Notes:   Data flips every half period so stale bits never look valid
`timescale 1ns/1ps
module hims_host (
   // Controls
   input  wire logic want_spi,
   input  wire logic frame,
   input  wire logic strap,
   // Pins
   output logic      sel_n,
   output logic      sck,
   output logic      sdo,
   output logic      addr1
);
   // Offset keeps pin edges off the core clock edges, so sampling never races
   initial begin
      sck = 1'b0;
      sdo = 1'b0;
      #1;
      forever begin
         #62.5;
         sck = frame ? ~sck : 1'b0;
         sdo = ~sdo;
      end
   end
   assign sel_n = !(want_spi && frame);
   assign addr1 = want_spi ? 1'b0 : strap;
endmodule : hims_host

// File: hims_top_tb.sv
// Purpose: Self-checking bench for the mode select block
// Assumes: Host model drives the serial pins
// Notes:   Random-pass outputs are compared 4 cycles after inputs settle
`timescale 1ns/1ps
module hims_top_tb;
   logic clk = 0, rstn = 0, ext_n = 1, want_spi = 0, frame = 0, strap = 0, a0 = 0;
   logic irq = 0, sda_oe = 0, so = 0, sel_n, sck, sdo, a1, d_o, d_oe, s_o, s_oe;
   logic irq_o, spi, rdy, i2c_a0, i2c_a1, cs_n;
   logic [15:0] sense = 0, sen_oe;
   logic [1:0]  refc = 0, ref_oe;
   logic [31:0] lfsr = 32'h0000_2c63;
   int mismatches = 0, n_checks = 0;
   wire sda_w = sdo & !d_oe;
   wire a0_w = s_oe ? s_o : a0;
   hims_host hims_host_i (.want_spi(want_spi), .frame(frame), .strap(strap), .sel_n(sel_n),
      .sck(sck), .sdo(sdo), .addr1(a1));
   hims_top hims_top_i (.CLK(clk), .RESETN(rstn), .EXTERNAL_RESET_N(ext_n),
      .MODE_SELECT_CHIP_SELECT_N(sel_n), .SERIAL_CLOCK_PIN(sck), .SERIAL_DATA_PIN_I(sda_w),
      .SERIAL_DATA_PIN_O(d_o), .SERIAL_DATA_PIN_OE(d_oe), .ADDR0_OR_SERIAL_OUT_PIN_I(a0_w),
      .ADDR0_OR_SERIAL_OUT_PIN_O(s_o), .ADDR0_OR_SERIAL_OUT_PIN_OE(s_oe), .ADDR1_SELECT_PIN(a1),
      .SENSE_INPUTS_OE(sen_oe), .REFERENCE_CAP_OE(ref_oe), .CORE_SENSE_OE(sense),
      .CORE_REF_OE(refc), .CORE_IRQ(irq), .CORE_I2C_SDA_OE(sda_oe), .CORE_SPI_SO(so),
      .INTERRUPT_OUTPUT(irq_o), .SPI_MODE(spi), .DEVICE_READY(rdy), .I2C_SCL(), .I2C_SDA(),
      .I2C_ADDR0(i2c_a0), .I2C_ADDR1(i2c_a1), .SPI_SCK(), .SPI_SI(), .SPI_CS_N(cs_n));
   always #2.5 clk = ~clk;
   function logic [31:0] nxt(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nxt
   task chk(string n, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task rnd;
      lfsr = nxt(lfsr);
      {a0, strap, so, sda_oe, irq, refc, sense} = lfsr[22:0];
      cyc(4);
      chk("sense_oe", sense, sen_oe);
      chk("ref_oe", refc, ref_oe);
      chk("irq", irq, irq_o);
   endtask : rnd
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   initial begin
      #10000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      cyc(8);
      rstn = 1;
      cyc(26);
      chk("ready", 1, rdy);
      chk("spi_mode", 0, spi);
      frame = 1;
      for (int i = 0; i < 30; i++) begin
         rnd();
         chk("sda_oe", sda_oe, d_oe);
         chk("addr0", a0, i2c_a0);
         chk("addr1", strap, i2c_a1);
         chk("so_oe", 0, s_oe);
         chk("sda_o", 0, d_o);
      end
      ext_n = 0;
      want_spi = 1;
      sense = 16'hffff;
      refc = 2'b11;
      cyc(3);
      chk("sense_oe", 0, sen_oe);
      chk("ref_oe", 0, ref_oe);
      cyc(20);
      chk("ready", 0, rdy);
      ext_n = 1;
      cyc(10);
      frame = 0;
      cyc(25);
      chk("spi_mode", 0, spi);
      frame = 1;
      cyc(6);
      chk("spi_mode", 1, spi);
      for (int i = 0; i < 20; i++) begin
         rnd();
         chk("so_oe", 1, s_oe);
         chk("so", so, s_o);
         chk("sda_oe", 0, d_oe);
         chk("addr1", 0, i2c_a1);
         chk("cs_n", 0, cs_n);
      end
      frame = 0;
      cyc(6);
      chk("spi_mode", 1, spi);
      chk("cs_n", 1, cs_n);
      chk("so_oe", 0, s_oe);
      ext_n = 0;
      want_spi = 0;
      cyc(5);
      ext_n = 1;
      cyc(26);
      chk("ready", 1, rdy);
      chk("spi_mode", 0, spi);
      rstn = 0;
      cyc(2);
      rstn = 1;
      cyc(26);
      chk("ready", 1, rdy);
      chk("spi_mode", 0, spi);
      report_and_stop();
   end
endmodule : hims_top_tb
